// ### hw/mms_controller.sv
// initiating controller end: makes the link clock, sends reset and wake
// runs of mode packets and request start bits on software command;
// assumes the plain register port of the system clock domain
`timescale 1ns/1ps
`default_nettype none
module mms_controller (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  // link to the device
  mms_link_if.ctl         link
);

  typedef enum logic [2:0] {
    c_idle, c_reset, c_relock, c_wake, c_offset, c_start, c_reply
  } mms_ctl_type;

  mms_ctl_type  st_reg;       // sequencer state
  logic [2:0]   div_reg;      // link clock divider phase
  logic         clk_reg;      // link clock out
  logic         en_reg;       // enable line out
  logic         ctrl_reg;     // start bit out
  logic [9:0]   slot_reg;     // packets sent in this phase
  logic [2:0]   wake_n_reg;   // wake packets to send
  logic         trans_reg;    // follow wake with a request
  logic         locked_reg;   // relock time has passed
  logic [1:0]   last_reply;   // reply captured for software
  logic [1:0]   rep_s1_reg;   // reply synchroniser, first stage
  logic [1:0]   rep_s2_reg;   // reply synchroniser, second stage
  logic         slot;         // a new packet begins to be driven
  logic         cmd_ok;       // command write accepted
  logic [2:0]   wake_req;     // requested wake count, clamped

  assign slot = div_reg == mms_pkg::LINK_DRIVE_PT;
  assign cmd_ok = i_wr && i_addr == mms_pkg::REG_CMD && st_reg == c_idle;
  // one to four wake packets only
  assign wake_req = (i_wdata[4:2] == 3'h0) ? 3'h1 :
    (i_wdata[4:2] > mms_pkg::WAKE_PACKET_MAX) ? mms_pkg::WAKE_PACKET_MAX :
    i_wdata[4:2];

  // link clock divider, high for the first half period
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      // low phase start keeps the link clock in step with its divider
      div_reg <= mms_pkg::LINK_HALF;
      clk_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      clk_reg <= (div_reg + 3'h1) < mms_pkg::LINK_HALF;
    end
  end

  // reply synchroniser; only the second stage is read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rep_s1_reg <= 2'h0;
      rep_s2_reg <= 2'h0;
    end else begin
      rep_s1_reg <= link.reply;
      rep_s2_reg <= rep_s1_reg;
    end
  end

  // sequencer: every slot decides what the next packet carries
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_reg <= c_idle;
      en_reg <= 1'b0;
      ctrl_reg <= 1'b0;
      slot_reg <= 10'h0;
      wake_n_reg <= 3'h1;
      trans_reg <= 1'b0;
      locked_reg <= 1'b1;
      last_reply <= mms_pkg::REPLY_NONE;
    end else begin
      if (cmd_ok && i_wdata[1:0] != mms_pkg::OP_NONE) begin
        st_reg <= (i_wdata[1:0] == mms_pkg::OP_RESET) ? c_reset : c_wake;
        wake_n_reg <= wake_req;
        trans_reg <= i_wdata[1:0] == mms_pkg::OP_TRANS && locked_reg;
        slot_reg <= 10'h0;
        locked_reg <= locked_reg && i_wdata[1:0] != mms_pkg::OP_RESET;
      end else if (slot) begin
        slot_reg <= slot_reg + 10'h1;
        en_reg <= 1'b0;
        ctrl_reg <= 1'b0;
        unique case (st_reg)
          c_idle: begin
            slot_reg <= 10'h0;
          end
          c_reset: begin
            en_reg <= 1'b1;
            // reset run plus settle time while held in reset
            if (slot_reg == 10'(mms_pkg::RESET_PACKET_COUNT) +
                mms_pkg::SETTLE_TIME - 10'h1) begin
              st_reg <= c_relock;
              slot_reg <= 10'h0;
            end
          end
          c_relock: begin
            if (slot_reg == mms_pkg::RELOCK_TIME) begin
              st_reg <= c_idle;
              locked_reg <= 1'b1;
            end
          end
          c_wake: begin
            en_reg <= 1'b1;
            if (slot_reg == 10'(wake_n_reg) - 10'h1) begin
              st_reg <= trans_reg ? c_offset : c_idle;
            end
          end
          c_offset: begin
            // one slot past the least offset so the device is active
            if (slot_reg > 10'(mms_pkg::WAKE_OFFSET_MIN)) begin
              st_reg <= c_start;
              ctrl_reg <= 1'b1;
              last_reply <= mms_pkg::REPLY_NONE;
              slot_reg <= 10'h0;
            end
          end
          c_start: begin
            st_reg <= c_reply;
            slot_reg <= 10'h0;
          end
          c_reply: begin
            if (slot_reg == mms_pkg::REPLY_WAIT) begin
              st_reg <= c_idle;
            end
          end
          default: begin
            st_reg <= c_idle;
          end
        endcase
      end
      if (st_reg == c_reply && rep_s2_reg != mms_pkg::REPLY_NONE) begin
        last_reply <= rep_s2_reg;
      end
    end
  end

  // read data one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= 8'h0;
    end else if (i_rd && i_addr == mms_pkg::REG_STATUS) begin
      o_rdata <= {4'h0, last_reply, locked_reg, st_reg != c_idle};
    end else begin
      o_rdata <= 8'h0;
    end
  end

  assign link.link_clk = clk_reg;
  assign link.enable_line = en_reg;
  assign link.bus_ctrl = ctrl_reg;

endmodule : mms_controller
`default_nettype wire

// ### hw/mms_device.sv
// responding device end: operating-mode state machine driven by runs of
// serial mode packets; assumes the controller end makes the link clock
//
// Chosen here: the user-side id-match and accept inputs and the status outputs.
`timescale 1ns/1ps
`default_nettype none
module mms_device #(
  parameter int ONES_W  = mms_pkg::ONES_W,
  parameter int ZEROS_W = mms_pkg::ZEROS_W
) (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // link to the controller
  mms_link_if.dev         link,
  // user side: addressing and acceptance of a framed request
  input  wire logic       i_id_match,
  input  wire logic       i_accept,
  // user side: status
  output logic [1:0]      o_mode,
  output logic            o_busy,
  output logic [7:0]      o_ones_run
);

  // framing machine states
  typedef enum logic [3:0] {
    power_apply_state,
    init_hold_state,
    idle_wait_state,
    decision_state,
    id_match_state,
    target_state,
    accept_state,
    refuse_state,
    reply_window_state
  } mms_state_type;

  mms_state_type        state_reg;          // current framing state
  mms_state_type        state_next;         // its next value
  logic [ONES_W-1:0]    ones_run_counter;   // code-11 run, in pairs
  logic                 ones_half_reg;      // low bit of the ones run
  logic [ZEROS_W-1:0]   zeros_run_counter;  // code-00 run
  logic [ONES_W:0]      ones_total;         // full ones run count
  logic                 fresh_reg;          // set from power-on until idle
  logic [3:0]           wake_cnt_reg;       // link cycles since wake packet
  logic                 wake_arm_reg;       // a wake packet has been seen
  logic [1:0]           win_cnt_reg;        // reply window length
  logic [1:0]           reply_reg;          // reply code on the link
  logic                 rise;               // link clock rising edge
  logic                 pkt_valid;          // a mode packet just closed
  logic [1:0]           pkt_code;           // its code
  logic                 start;              // request start bit seen
  logic                 reset_hit;          // ones run at reset count
  logic                 wake_hit;           // ones run at wake count
  logic                 timeout_hit;        // zeros run at wake timeout

  // pin synchroniser and packet framer
  mms_link_sampler u_sampler (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_link_clk  (link.link_clk),
    .i_enable    (link.enable_line),
    .i_ctrl      (link.bus_ctrl),
    .o_rise      (rise),
    .o_pkt_valid (pkt_valid),
    .o_pkt_code  (pkt_code),
    .o_start     (start)
  );

  // the ones run is nine bits wide in total so that 320 fits; the
  // eight-bit counter holds the run in pairs of packets
  assign ones_total = {ones_run_counter, ones_half_reg};
  assign reset_hit = ones_total >= mms_pkg::RESET_PACKET_COUNT;
  assign wake_hit = ones_total >= mms_pkg::WAKE_PACKET_MIN;
  // integer compare cuts neither side; a four-bit run never reaches 20
  assign timeout_hit =
    int'(zeros_run_counter) >= int'(mms_pkg::WAKE_TIMEOUT);

  // run counters; codes 01 and 10 leave both untouched
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ones_run_counter <= '0;
      ones_half_reg <= 1'b0;
      zeros_run_counter <= '0;
    end else if (pkt_valid) begin
      unique case (pkt_code)
        mms_pkg::CODE_11: begin
          zeros_run_counter <= '0;
          if (~&ones_total) begin
            {ones_run_counter, ones_half_reg} <= ones_total + 1'b1;
          end
        end
        mms_pkg::CODE_00: begin
          ones_run_counter <= '0;
          ones_half_reg <= 1'b0;
          if (~&zeros_run_counter) begin
            zeros_run_counter <= zeros_run_counter + 1'b1;
          end
        end
        default: begin
          ones_half_reg <= ones_half_reg;
        end
      endcase
    end
  end

  // next-state choice; a reset run overrides every state but power_apply_state
  always_comb begin
    state_next = state_reg;
    if (state_reg != power_apply_state && reset_hit) begin
      state_next = init_hold_state;
    end else begin
      unique case (state_reg)
        power_apply_state: begin
          state_next = init_hold_state;
        end
        init_hold_state: begin
          // stays while 11s arrive; a 00 clears the run
          if (!wake_hit) begin
            state_next = decision_state;
          end
        end
        idle_wait_state: begin
          // active once the offset from the first wake packet has run
          if (wake_arm_reg && rise &&
              wake_cnt_reg == mms_pkg::WAKE_OFFSET_MIN - 4'h1) begin
            state_next = decision_state;
          end
        end
        decision_state: begin
          if (fresh_reg) begin
            state_next = idle_wait_state;
          end else if (start) begin
            state_next = id_match_state;
          end else if (timeout_hit) begin
            state_next = idle_wait_state;
          end
        end
        id_match_state: begin
          if (rise) begin
            state_next = i_id_match ? target_state : idle_wait_state;
          end
        end
        target_state: begin
          if (rise) begin
            state_next = i_accept ? accept_state : refuse_state;
          end
        end
        accept_state, refuse_state: begin
          state_next = reply_window_state;
        end
        reply_window_state: begin
          if (rise && win_cnt_reg == mms_pkg::REPLY_WINDOW - 2'h1) begin
            state_next = idle_wait_state;
          end
        end
        default: begin
          state_next = init_hold_state;
        end
      endcase
    end
  end

  // state register and mode output, both from power-on defined
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg <= power_apply_state;
      o_mode <= mms_pkg::MODE_RESET;
      o_busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      o_busy <= state_next != power_apply_state &&
                state_next != init_hold_state &&
                state_next != idle_wait_state &&
                state_next != decision_state;
      if (state_next == power_apply_state ||
          state_next == init_hold_state) begin
        o_mode <= mms_pkg::MODE_RESET;
      end else if (state_next == idle_wait_state) begin
        o_mode <= mms_pkg::MODE_STANDBY;
      end else begin
        o_mode <= mms_pkg::MODE_ACTIVE;
      end
    end
  end

  // power-up marker: cleared once the device first rests in standby
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fresh_reg <= 1'b1;
    end else if (state_reg == idle_wait_state) begin
      fresh_reg <= 1'b0;
    end
  end

  // wake offset counter, counted in link rising edges
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || state_reg != idle_wait_state) begin
      wake_arm_reg <= 1'b0;
      wake_cnt_reg <= 4'h0;
    end else if (!wake_arm_reg) begin
      // a short wake run still counts from its first packet
      wake_arm_reg <= wake_hit;
    end else if (rise) begin
      wake_cnt_reg <= wake_cnt_reg + 4'h1;
    end
  end

  // reply window: code is held for a fixed number of link cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || state_reg == init_hold_state) begin
      reply_reg <= mms_pkg::REPLY_NONE;
      win_cnt_reg <= 2'h0;
    end else if (state_reg == accept_state) begin
      reply_reg <= mms_pkg::REPLY_OKAY;
      win_cnt_reg <= 2'h0;
    end else if (state_reg == refuse_state) begin
      reply_reg <= mms_pkg::REPLY_NACK;
      win_cnt_reg <= 2'h0;
    end else if (state_reg == reply_window_state) begin
      if (rise) begin
        win_cnt_reg <= win_cnt_reg + 2'h1;
      end
      // drop the code with the mode, so no reply stands in standby
      if (state_next != reply_window_state) begin
        reply_reg <= mms_pkg::REPLY_NONE;
      end
    end else begin
      reply_reg <= mms_pkg::REPLY_NONE;
    end
  end

  assign link.reply = reply_reg;

  // observation copy of the run counter
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_ones_run <= 8'h0;
    end else begin
      o_ones_run <= 8'(ones_run_counter);
    end
  end

endmodule : mms_device
`default_nettype wire

// ### hw/mms_link_sampler.sv
// link receiver: synchronises the link pins and frames one mode packet
// per link cycle; assumes the link clock is far slower than i_clk_sys
`timescale 1ns/1ps
`default_nettype none
module mms_link_sampler (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // raw link pins
  input  wire logic       i_link_clk,
  input  wire logic       i_enable,
  input  wire logic       i_ctrl,
  // framed events
  output logic            o_rise,
  output logic            o_pkt_valid,
  output logic [1:0]      o_pkt_code,
  output logic            o_start
);

  logic [1:0] clk_sync_reg;  // first stage read only by the second
  logic [1:0] en_sync_reg;
  logic [1:0] ctl_sync_reg;
  logic       clk_last_reg;  // edge detect stage behind the synchroniser
  logic       bit0_reg;      // first half of the current packet

  // two-flop synchronisers on every pin
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      clk_sync_reg <= 2'h0;
      en_sync_reg <= 2'h0;
      ctl_sync_reg <= 2'h0;
      clk_last_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], i_link_clk};
      en_sync_reg <= {en_sync_reg[0], i_enable};
      ctl_sync_reg <= {ctl_sync_reg[0], i_ctrl};
      clk_last_reg <= clk_sync_reg[1];
    end
  end

  // bit 0 at the rising edge, bit 1 at the falling edge closes the packet
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bit0_reg <= 1'b0;
      o_rise <= 1'b0;
      o_pkt_valid <= 1'b0;
      o_pkt_code <= 2'h0;
      o_start <= 1'b0;
    end else begin
      o_rise <= clk_sync_reg[1] & ~clk_last_reg;
      o_start <= clk_sync_reg[1] & ~clk_last_reg & ctl_sync_reg[1];
      o_pkt_valid <= ~clk_sync_reg[1] & clk_last_reg;
      if (clk_sync_reg[1] & ~clk_last_reg) begin
        bit0_reg <= en_sync_reg[1];
      end
      if (~clk_sync_reg[1] & clk_last_reg) begin
        o_pkt_code <= {en_sync_reg[1], bit0_reg};
      end
    end
  end

endmodule : mms_link_sampler
`default_nettype wire

// ### shared/mms_link_if.sv
// link wires between the initiating controller and the memory device
// assumes the bench instantiates it and hands one modport to each end
`timescale 1ns/1ps
`default_nettype none
interface mms_link_if;
  logic       link_clk;    // link clock, made by the controller
  logic       enable_line; // serial mode packets, idles low
  logic       bus_ctrl;    // request start bit
  logic [1:0] reply;       // device reply code

  modport dev (input link_clk, input enable_line, input bus_ctrl,
               output reply);
  modport ctl (output link_clk, output enable_line, output bus_ctrl,
               input reply);
endinterface : mms_link_if
`default_nettype wire

// ### shared/mms_pkg.sv
// constants shared by both ends of the mode-packet link
// assumes a 20 MHz system clock at each end and one mode packet per link cycle
package mms_pkg;

  // counter widths
  localparam int ONES_W = 8;
  localparam int ZEROS_W = 4;

  // mode packet codes on the enable line
  localparam logic [1:0] CODE_00 = 2'h0;
  localparam logic [1:0] CODE_11 = 2'h3;

  // packet counts and link-cycle times
  localparam logic [8:0] RESET_PACKET_COUNT = 9'h140; // 320 packets
  localparam logic [8:0] WAKE_PACKET_MIN = 9'h001;
  localparam logic [2:0] WAKE_PACKET_MAX = 3'h4;
  localparam logic [3:0] WAKE_OFFSET_MIN = 4'h4;
  localparam logic [3:0] WAKE_OFFSET_MAX = 4'h7;
  localparam logic [4:0] WAKE_TIMEOUT = 5'h14;       // 20 cycles
  localparam logic [9:0] SETTLE_TIME = 10'h020;      // 32 cycles
  localparam logic [9:0] RELOCK_TIME = 10'h2ee;      // 750 cycles
  localparam logic [1:0] REPLY_WINDOW = 2'h2;        // link cycles of reply
  localparam logic [9:0] REPLY_WAIT = 10'h00c;       // controller waits this

  // link clock divider: system cycles per link half period (400 ns link)
  localparam logic [2:0] LINK_HALF = 3'h4;
  localparam logic [2:0] LINK_DRIVE_PT = 3'h6;       // data change point

  // reply codes
  localparam logic [1:0] REPLY_NONE = 2'h0;
  localparam logic [1:0] REPLY_OKAY = 2'h1;
  localparam logic [1:0] REPLY_NACK = 2'h2;

  // controller register map (word index on the plain port)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_RESET = 2'h1;
  localparam logic [1:0] OP_WAKE = 2'h2;
  localparam logic [1:0] OP_TRANS = 2'h3;

  // operating mode reported by the device
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_ACTIVE = 2'h2;

endpackage : mms_pkg

// ### tb/mms_link_props.sv
// checker for the mode-packet link and the device's reported mode
// assumes the bench wires it beside the link interface
`timescale 1ns/1ps
`default_nettype none
module mms_link_props (
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  // link wires and device mode
  input wire logic       link_clk,
  input wire logic       enable_line,
  input wire logic       bus_ctrl,
  input wire logic [1:0] reply,
  input wire logic [1:0] o_mode
);
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  quiet_link_a: assert property ($fell(i_rst) |-> !enable_line &&
    !bus_ctrl && reply == mms_pkg::REPLY_NONE) else $error("link not idle");
  boot_standby_a: assert property ($fell(i_rst) |-> ##[1:4]
    o_mode == mms_pkg::MODE_STANDBY) else $error("no standby after boot");
  link_half_a: assert property ($rose(link_clk) |->
    link_clk[*4] ##1 !link_clk) else $error("link clock half period");
  whole_pkt_a: assert property ($changed(enable_line) |->
    !link_clk) else $error("enable changed inside a packet");
  start_len_a: assert property ($rose(bus_ctrl) |->
    bus_ctrl[*8] ##1 !bus_ctrl) else $error("start bit length");
  wake_active_a: assert property (o_mode == mms_pkg::MODE_STANDBY &&
    $rose(enable_line) |-> ##[1:48] o_mode == mms_pkg::MODE_ACTIVE)
    else $error("wake too slow");
  reset_exit_a: assert property ($past(o_mode) == mms_pkg::MODE_RESET &&
    o_mode != mms_pkg::MODE_RESET |-> o_mode == mms_pkg::MODE_ACTIVE)
    else $error("reset left to wrong mode");
  reset_holds_a: assert property (o_mode == mms_pkg::MODE_RESET &&
    enable_line |=> o_mode == mms_pkg::MODE_RESET) else $error("left reset");
  reply_mode_a: assert property (reply != mms_pkg::REPLY_NONE |->
    o_mode == mms_pkg::MODE_ACTIVE) else $error("reply outside active");
  reply_hold_a: assert property (reply != mms_pkg::REPLY_NONE &&
    $past(reply) == mms_pkg::REPLY_NONE |=> (reply != mms_pkg::REPLY_NONE)[*8])
    else $error("reply too short");

  // main scenarios reached
  cover property (o_mode == mms_pkg::MODE_RESET);
  cover property (reply == mms_pkg::REPLY_OKAY);
  cover property (reply == mms_pkg::REPLY_NACK);
endmodule : mms_link_props
`default_nettype wire

// ### tb/tb_memory_mode_state_machine.sv
// bench: controller and device joined by the link interface
// assumes the shared package and interface are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_memory_mode_state_machine;
  // stimulus and observed signals
  logic       i_clk_sys   = 1'b0;
  logic       i_rst       = 1'b1;
  logic [3:0] i_addr      = 4'h0;
  logic [7:0] i_wdata     = 8'h00;
  logic       i_wr        = 1'b0;
  logic       i_rd        = 1'b0;
  logic [7:0] o_rdata;
  logic       id_match    = 1'b1; // device addressed unless a test clears it
  logic       accept      = 1'b1; // okay or nack choice
  logic [1:0] o_mode;
  logic       o_busy;
  logic [7:0] o_ones_run;
  logic [7:0] d;                  // last read data
  int         n_mismatch  = 0;
  int         checks_done = 0;
  int         busy_cycles = 0;    // cycles the device reported busy

  // 20 MHz system clock
  always #25 i_clk_sys = ~i_clk_sys;

  // count busy cycles so that framing is seen to happen
  always @(posedge i_clk_sys) begin
    if (o_busy === 1'b1) busy_cycles <= busy_cycles + 1;
  end

  mms_link_if lnk ();
  // wider zeros counter so the 20-packet timeout is reachable
  mms_device #(.ONES_W(8), .ZEROS_W(5)) i_mms_device (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(lnk.dev),
    .i_id_match(id_match), .i_accept(accept), .o_mode(o_mode),
    .o_busy(o_busy), .o_ones_run(o_ones_run));
  mms_controller i_mms_controller (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .link(lnk.ctl));
  mms_link_props i_mms_link_props (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .link_clk(lnk.link_clk),
    .enable_line(lnk.enable_line), .bus_ctrl(lnk.bus_ctrl),
    .reply(lnk.reply), .o_mode(o_mode));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_mode(input logic [1:0] m);
    chk({7'h0, o_mode}, {7'h0, m});
  endtask : chk_mode

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  // poll status until the controller is no longer busy
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    do begin
      rd(mms_pkg::REG_STATUS);
      k++;
    end while (d[0] !== 1'b0 && k < lim);
    chk({8'h0, d[0]}, 9'h000);
  endtask : wait_idle

  task automatic wait_mode(input logic [1:0] m, input int lim);
    for (int k = 0; k < lim && o_mode !== m; k++) tick(1);
    chk_mode(m);
  endtask : wait_mode

  task automatic t_boot;
    chk_mode(mms_pkg::MODE_STANDBY);
    chk({o_busy, o_ones_run}, 9'h000);
    rd(mms_pkg::REG_STATUS);
    chk({1'b0, d}, 9'h002);
    rd(4'h5);
    chk({1'b0, d}, 9'h000);
  endtask : t_boot

  // wake counts 0..6 clamp to 1..4; accept alternates okay and nack;
  // the last pass is not addressed and must get no reply
  task automatic t_trans;
    for (int n = 0; n < 7; n++) begin
      tick(1);
      accept <= n[0];
      id_match <= n != 6;
      wr(mms_pkg::REG_CMD, {3'h0, n[2:0], mms_pkg::OP_TRANS});
      wait_idle(400);
      chk({7'h0, d[3:2]}, (n == 6) ? 9'h000 : n[0] ? 9'h001 : 9'h002);
      chk_mode(mms_pkg::MODE_STANDBY);
    end
    chk({8'h0, busy_cycles != 0}, 9'h001);
  endtask : t_trans

  // a wake with no request falls back to standby after 20 zeros
  task automatic t_timeout;
    wr(mms_pkg::REG_CMD, {3'h0, 3'h1, mms_pkg::OP_WAKE});
    tick(140);
    chk_mode(mms_pkg::MODE_ACTIVE);
    tick(70);
    chk_mode(mms_pkg::MODE_STANDBY);
  endtask : t_timeout

  // long run of ones forces reset, the first zero leaves it
  task automatic t_reset_run;
    wait_idle(400);
    wr(mms_pkg::REG_CMD, {6'h00, mms_pkg::OP_RESET});
    tick(2400);
    chk({8'h0, o_mode === mms_pkg::MODE_RESET}, 9'h000);
    wait_mode(mms_pkg::MODE_RESET, 400);
    tick(200);
    chk_mode(mms_pkg::MODE_RESET);
    wait_mode(mms_pkg::MODE_ACTIVE, 200);
    rd(mms_pkg::REG_STATUS);
    chk({8'h0, d[1]}, 9'h000);
    wait_mode(mms_pkg::MODE_STANDBY, 300);
    wait_idle(4000);
    chk({8'h0, d[1]}, 9'h001);
  endtask : t_reset_run

  // main sequence
  initial begin
    tick(12);
    i_rst <= 1'b0;
    tick(6);
    t_boot();
    t_trans();
    t_timeout();
    t_reset_run();
    end_of_test();
  end

  // watchdog well beyond the expected run length
  initial begin
    #1500000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_memory_mode_state_machine
`default_nettype wire
